// File: pkg/lsi_regs.vh
// Register map, field positions and reset values of the status unit
`ifndef LSI_REGS_VH
`define LSI_REGS_VH

// Register offsets on the parallel control port
`define LSI_ADDR_STATUS_ONE   8'h06
`define LSI_ADDR_STATUS_TWO   8'h07
`define LSI_ADDR_RX_INFO      8'h08
`define LSI_ADDR_IRQ_MASK_ONE 8'h16
`define LSI_ADDR_IRQ_MASK_TWO 8'h17
`define LSI_ADDR_SYNC_STATUS  8'h1E

// Status register one: event bits above, alarm bits below
`define LSI_SR1_ALARM_BITS    8'h0F
`define LSI_SR1_EVENT_BITS    8'hF0
`define LSI_SR1_UNFRAMED_POS  3
`define LSI_SR1_REMOTE_POS    2
`define LSI_SR1_CARRIER_POS   1
`define LSI_SR1_SYNCLOSS_POS  0

// Receive information flag positions
`define LSI_RIR_TX_FULL_POS   7
`define LSI_RIR_TX_EMPTY_POS  6
`define LSI_RIR_JITTER_POS    5
`define LSI_RIR_RX_FULL_POS   4
`define LSI_RIR_RX_EMPTY_POS  3
`define LSI_RIR_CRC_POS       2
`define LSI_RIR_FAS_POS       1
`define LSI_RIR_CAS_POS       0

// Reset values
`define LSI_RST_STATUS        8'h00
`define LSI_RST_MASK          8'h00
`define LSI_RST_READ_DATA     8'h00
`define LSI_UNMAPPED_READ     8'h00

`endif

// File: src/lsi_latched_status_irq_unit.v
// Latched status registers, live sync status and interrupt output
//
// Notes on behaviour
// - Latched bits set on event, held until read
// - Read-cleared event bit waits for new event
// - Active alarm bits re-set right after read
// - Mask one bit refreshes readable image bit
// - Mask zero bit keeps previous readable value
// - Sync status register is live, read-only
// - Status flags drive interrupt via mask registers
// - Alarm change either way raises interrupt
// - Reading alarm bit releases its interrupt
// - Event raises interrupt, read releases it
// - Bit 7 set on transmit store full
// - Bit 6 set on transmit store empty
// - Bit 5 set on jitter buffer near limit
// - Bit 4 set on receive store full
// - Bit 3 set on receive store empty
// - Bit 2 set on CRC resync criterion
// - Bit 0 set on CAS resync criterion
`timescale 1ns/1ps
`default_nettype none
`include "lsi_regs.vh"

module lsi_latched_status_irq_unit #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [7:0]       busAddr,
    input  wire             busWrStb,
    input  wire             busRdStb,
    input  wire [WIDTH-1:0] busWrData,
    output reg  [WIDTH-1:0] busRdData,
    output reg              intN,
    input  wire [3:0]       sr1Events,
    input  wire             unframedAllOnesAlarm,
    input  wire             remoteAlarmFlag,
    input  wire             carrierLossAlarm,
    input  wire             syncLossAlarm,
    input  wire [WIDTH-1:0] sr2Events,
    input  wire             txElasticFull,
    input  wire             txElasticEmpty,
    input  wire             jitterBufferLimitTrip,
    input  wire             rxElasticFull,
    input  wire             rxElasticEmpty,
    input  wire             crcResyncMet,
    input  wire             frameAlignResyncMet,
    input  wire             multiframeResyncMet,
    input  wire [WIDTH-1:0] synchronizerState
);

    // Raw asynchronous inputs gathered for synchronising
    // Bits 7..4 of status one are events, bits 3..0 alarms
    wire [WIDTH-1:0] rawSr1;
    wire [WIDTH-1:0] rawRir;
    wire [4*WIDTH-1:0] rawAll;

    assign rawSr1 = {sr1Events,
                     unframedAllOnesAlarm,
                     remoteAlarmFlag,
                     carrierLossAlarm,
                     syncLossAlarm};
    assign rawRir = {txElasticFull,
                     txElasticEmpty,
                     jitterBufferLimitTrip,
                     rxElasticFull,
                     rxElasticEmpty,
                     crcResyncMet,
                     frameAlignResyncMet,
                     multiframeResyncMet};
    assign rawAll = {synchronizerState, rawRir, sr2Events, rawSr1};

    // Synchroniser pair and previous sample for edge detection;
    // every source is asynchronous, so logic reads only syncB_q and prev_q
    reg [4*WIDTH-1:0] syncA_q;
    reg [4*WIDTH-1:0] syncB_q;
    reg [4*WIDTH-1:0] prev_q;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA_q <= {4*WIDTH{1'b0}};
            syncB_q <= {4*WIDTH{1'b0}};
            prev_q  <= {4*WIDTH{1'b0}};
        end else begin
            syncA_q <= rawAll;
            syncB_q <= syncA_q;
            prev_q  <= syncB_q;
        end
    end

    // Live status word passed on only once two samples agree, so a
    // word caught in mid-change never reaches the reader
    wire [WIDTH-1:0] curSync;
    wire [WIDTH-1:0] prvSync;
    reg  [WIDTH-1:0] liveSync_q;

    assign curSync = syncB_q[4*WIDTH-1:3*WIDTH];
    assign prvSync = prev_q[4*WIDTH-1:3*WIDTH];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            liveSync_q <= `LSI_RST_STATUS;
        end else if (curSync == prvSync) begin
            liveSync_q <= prvSync;
        end
    end

    // Synchronised views
    wire [WIDTH-1:0] lvlSr1;
    wire [WIDTH-1:0] lvlSr2;
    wire [WIDTH-1:0] lvlRir;
    wire [WIDTH-1:0] liveSync;
    wire [WIDTH-1:0] prvSr1;
    wire [WIDTH-1:0] prvSr2;
    wire [WIDTH-1:0] prvRir;

    assign lvlSr1   = syncB_q[WIDTH-1:0];
    assign lvlSr2   = syncB_q[2*WIDTH-1:WIDTH];
    assign lvlRir   = syncB_q[3*WIDTH-1:2*WIDTH];
    assign liveSync = liveSync_q;
    assign prvSr1   = prev_q[WIDTH-1:0];
    assign prvSr2   = prev_q[2*WIDTH-1:WIDTH];
    assign prvRir   = prev_q[3*WIDTH-1:2*WIDTH];

    // Alarm and event masks of status register one
    wire [WIDTH-1:0] alarmBits;
    wire [WIDTH-1:0] eventBits;

    assign alarmBits = `LSI_SR1_ALARM_BITS;
    assign eventBits = `LSI_SR1_EVENT_BITS;

    // Latch set terms: rising edge for events, level for alarms
    // Alarm level re-sets its bit every cycle the alarm lasts
    wire [WIDTH-1:0] setSr1;
    wire [WIDTH-1:0] setSr2;
    wire [WIDTH-1:0] setRir;

    assign setSr1 = (lvlSr1 & ~prvSr1 & eventBits)
                  | (lvlSr1 & alarmBits);
    assign setSr2 = lvlSr2 & ~prvSr2;
    assign setRir = lvlRir & ~prvRir;

    // Interrupt set terms: alarms on either change, events on edge
    // Information flags have no interrupt path
    wire [WIDTH-1:0] irqSetSr1;
    wire [WIDTH-1:0] irqSetSr2;

    assign irqSetSr1 = ((lvlSr1 ^ prvSr1) & alarmBits)
                     | (lvlSr1 & ~prvSr1 & eventBits);
    assign irqSetSr2 = lvlSr2 & ~prvSr2;

    // Address decode of the control port
    // Full eight-bit compare, so no offset aliases another
    wire hitSr1;
    wire hitSr2;
    wire hitRir;
    wire hitImr1;
    wire hitImr2;
    wire hitSsr;

    assign hitSr1  = (busAddr == `LSI_ADDR_STATUS_ONE);
    assign hitSr2  = (busAddr == `LSI_ADDR_STATUS_TWO);
    assign hitRir  = (busAddr == `LSI_ADDR_RX_INFO);
    assign hitImr1 = (busAddr == `LSI_ADDR_IRQ_MASK_ONE);
    assign hitImr2 = (busAddr == `LSI_ADDR_IRQ_MASK_TWO);
    assign hitSsr  = (busAddr == `LSI_ADDR_SYNC_STATUS);

    // Latched flags, readable images and pending read masks
    reg [WIDTH-1:0] latSr1_q;
    reg [WIDTH-1:0] latSr2_q;
    reg [WIDTH-1:0] latRir_q;
    reg [WIDTH-1:0] imgSr1_q;
    reg [WIDTH-1:0] imgSr2_q;
    reg [WIDTH-1:0] imgRir_q;
    reg [WIDTH-1:0] pendSr1_q;
    reg [WIDTH-1:0] pendSr2_q;
    reg [WIDTH-1:0] pendRir_q;
    reg [WIDTH-1:0] irq_mask_one_q;
    reg [WIDTH-1:0] irq_mask_two_q;
    reg [WIDTH-1:0] irqSr1_q;
    reg [WIDTH-1:0] irqSr2_q;

    // Bits a read clears: captured as one and asked for by the mask
    // A bit the reader never saw as one stays latched
    wire [WIDTH-1:0] clrSr1;
    wire [WIDTH-1:0] clrSr2;
    wire [WIDTH-1:0] clrRir;
    wire [WIDTH-1:0] seenSr1;
    wire [WIDTH-1:0] seenSr2;

    assign clrSr1  = (busRdStb && hitSr1) ? (imgSr1_q & pendSr1_q)
                                          : {WIDTH{1'b0}};
    assign clrSr2  = (busRdStb && hitSr2) ? (imgSr2_q & pendSr2_q)
                                          : {WIDTH{1'b0}};
    assign clrRir  = (busRdStb && hitRir) ? (imgRir_q & pendRir_q)
                                          : {WIDTH{1'b0}};
    assign seenSr1 = (busRdStb && hitSr1) ? pendSr1_q : {WIDTH{1'b0}};
    assign seenSr2 = (busRdStb && hitSr2) ? pendSr2_q : {WIDTH{1'b0}};

    // Next latched values: set wins over the read clear
    wire [WIDTH-1:0] latSr1_d;
    wire [WIDTH-1:0] latSr2_d;
    wire [WIDTH-1:0] latRir_d;

    assign latSr1_d = (latSr1_q & ~clrSr1) | setSr1;
    assign latSr2_d = (latSr2_q & ~clrSr2) | setSr2;
    assign latRir_d = (latRir_q & ~clrRir) | setRir;

    // Latched flag registers
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            latSr1_q <= `LSI_RST_STATUS;
            latSr2_q <= `LSI_RST_STATUS;
            latRir_q <= `LSI_RST_STATUS;
        end else begin
            latSr1_q <= latSr1_d;
            latSr2_q <= latSr2_d;
            latRir_q <= latRir_d;
        end
    end

    // Status one image: a mask write refreshes chosen bits only
    // and remembers which bits the following read may clear
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            imgSr1_q  <= `LSI_RST_STATUS;
            pendSr1_q <= `LSI_RST_MASK;
        end else if (busWrStb && hitSr1) begin
            imgSr1_q  <= (latSr1_q & busWrData)
                       | (imgSr1_q & ~busWrData);
            pendSr1_q <= busWrData;
        end else if (busRdStb && hitSr1) begin
            pendSr1_q <= `LSI_RST_MASK;
        end
    end

    // Status two image and pending read mask
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            imgSr2_q  <= `LSI_RST_STATUS;
            pendSr2_q <= `LSI_RST_MASK;
        end else if (busWrStb && hitSr2) begin
            imgSr2_q  <= (latSr2_q & busWrData)
                       | (imgSr2_q & ~busWrData);
            pendSr2_q <= busWrData;
        end else if (busRdStb && hitSr2) begin
            pendSr2_q <= `LSI_RST_MASK;
        end
    end

    // Information image and pending read mask
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            imgRir_q  <= `LSI_RST_STATUS;
            pendRir_q <= `LSI_RST_MASK;
        end else if (busWrStb && hitRir) begin
            imgRir_q  <= (latRir_q & busWrData)
                       | (imgRir_q & ~busWrData);
            pendRir_q <= busWrData;
        end else if (busRdStb && hitRir) begin
            pendRir_q <= `LSI_RST_MASK;
        end
    end

    // Interrupt mask registers
    // Readable, so the host can check what it enabled
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask_one_q <= `LSI_RST_MASK;
            irq_mask_two_q <= `LSI_RST_MASK;
        end else begin
            if (busWrStb && hitImr1) begin
                irq_mask_one_q <= busWrData;
            end
            if (busWrStb && hitImr2) begin
                irq_mask_two_q <= busWrData;
            end
        end
    end

    // Status one interrupt pending bits; a read covering a bit
    // releases it, while a new change in that cycle wins
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqSr1_q <= `LSI_RST_STATUS;
        end else begin
            irqSr1_q <= (irqSr1_q & ~seenSr1) | irqSetSr1;
        end
    end

    // Status two interrupt pending bits, event kind only
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irqSr2_q <= `LSI_RST_STATUS;
        end else begin
            irqSr2_q <= (irqSr2_q & ~seenSr2) | irqSetSr2;
        end
    end

    // Active-low interrupt pin from any enabled pending source
    // Registered, so the pin never glitches between sources
    wire anyIrq;

    assign anyIrq = |((irqSr1_q & irq_mask_one_q) | (irqSr2_q & irq_mask_two_q));

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            intN <= 1'b1;
        end else begin
            intN <= ~anyIrq;
        end
    end

    // Read data mux; unmapped offsets read zero
    // Writes to the live status offset fall through unused
    reg [WIDTH-1:0] rdMux;

    always @* begin
        rdMux = `LSI_UNMAPPED_READ;
        case (1'b1)
            hitSr1:  rdMux = imgSr1_q;
            hitSr2:  rdMux = imgSr2_q;
            hitRir:  rdMux = imgRir_q;
            hitImr1: rdMux = irq_mask_one_q;
            hitImr2: rdMux = irq_mask_two_q;
            hitSsr:  rdMux = liveSync;
            default: rdMux = `LSI_UNMAPPED_READ;
        endcase
    end

    // Read data register, loaded on each read strobe
    // and held between reads for the host to pick up
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busRdData <= `LSI_RST_READ_DATA;
        end else if (busRdStb) begin
            busRdData <= rdMux;
        end
    end

endmodule
`default_nettype wire

// File: sim/lsi_unit_checker.sv
// Port-level assertions for the latched status and interrupt unit
`timescale 1ns/1ps
`default_nettype none
module lsi_unit_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] busAddr,
    input wire logic       busWrStb,
    input wire logic       busRdStb,
    input wire logic [7:0] busWrData,
    input wire logic [7:0] busRdData,
    input wire logic       intN,
    input wire logic [3:0] sr1Events,
    input wire logic       unframedAllOnesAlarm,
    input wire logic       remoteAlarmFlag,
    input wire logic       carrierLossAlarm,
    input wire logic       syncLossAlarm,
    input wire logic [7:0] sr2Events,
    input wire logic [7:0] synchronizerState
);
    logic [3:0] accAge_q;
    logic [3:0] srcAge_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Saturating ages of the last access and the last source change
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            accAge_q <= 4'hF;
            srcAge_q <= 4'hF;
        end else begin
            accAge_q <= (busWrStb | busRdStb) ? 4'h0
                      : accAge_q + {3'h0, accAge_q != 4'hF};
            srcAge_q <= $changed({sr1Events, unframedAllOnesAlarm,
                        remoteAlarmFlag, carrierLossAlarm, syncLossAlarm,
                        sr2Events}) ? 4'h0
                      : srcAge_q + {3'h0, srcAge_q != 4'hF};
        end
    end
    // Mask register write and a steady live status input
    sequence maskWr;
        busWrStb && (busAddr == 8'h16 || busAddr == 8'h17);
    endsequence
    sequence syncSteady;
        $stable(synchronizerState) [*4];
    endsequence
    rst_int_a: assert property ($rose(nrst) |-> intN)
        else $error("interrupt low right after reset");
    rst_data_a: assert property ($rose(nrst) |-> busRdData == 8'h00)
        else $error("read data not cleared by reset");
    rd_hold_a: assert property ($changed(busRdData)
        |-> $past(busRdStb) || $past(busRdStb, 2))
        else $error("read data moved without a read");
    unmapped_rd_a: assert property ((busRdStb && busAddr >= 8'h20)
        ##1 !busRdStb |=> busRdData == 8'h00)
        else $error("unmapped read not zero");
    mask_back_a: assert property (maskWr ##1 (busRdStb
        && busAddr == $past(busAddr)) ##1 !busRdStb
        |=> busRdData == $past(busWrData, 3))
        else $error("mask readback differs");
    sync_live_a: assert property (syncSteady ##0 (busRdStb
        && busAddr == 8'h1E) ##1 !busRdStb
        |=> busRdData == $past(synchronizerState, 2))
        else $error("live status read wrong");
    int_rel_a: assert property ($rose(intN) |-> accAge_q <= 4'd5)
        else $error("interrupt released without access");
    int_fall_a: assert property ($fell(intN)
        |-> srcAge_q <= 4'd7 || accAge_q <= 4'd5)
        else $error("interrupt raised without cause");
endmodule
`default_nettype wire

// File: sim/lsi_host_model.sv
// Host controller model on the parallel control port
`timescale 1ns/1ps
`default_nettype none
module lsi_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] busRdData,
    output logic      [7:0] busAddr,
    output logic            busWrStb,
    output logic            busRdStb,
    output logic      [7:0] busWrData
);
    initial begin
        busAddr = 8'h00;
        busWrStb = 1'b0;
        busRdStb = 1'b0;
        busWrData = 8'h00;
    end
    // One bus cycle, launched at an edge and taken at the next
    task cyc(input logic w, input logic r, input logic [7:0] a,
             input logic [7:0] v);
        busAddr <= a;
        busWrStb <= w;
        busRdStb <= r;
        busWrData <= v;
        @(posedge clk);
    endtask
    task idle(input int n);
        repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
    endtask
    task rd(input logic [7:0] a, output logic [7:0] d);
        cyc(1'b0, 1'b1, a, 8'h00);
        idle(2);
        d = busRdData;
    endtask
    // Mask write, read, then write back the masked result
    task poll(input logic [7:0] a, input logic [7:0] m,
              output logic [7:0] d);
        cyc(1'b1, 1'b0, a, m);
        rd(a, d);
        cyc(1'b1, 1'b0, a, d & m);
        idle(1);
    endtask
endmodule
`default_nettype wire

// File: sim/lsi_latched_status_irq_unit_tb.sv
// Self-checking bench for the latched status and interrupt unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    mismatches++; $display("ERROR %0t: got %h want %h", $time, a, b); \
    end end
module lsi_latched_status_irq_unit_tb;
    logic       clk;
    logic       nrst;
    wire  [7:0] busAddr;
    wire        busWrStb;
    wire        busRdStb;
    wire  [7:0] busWrData;
    wire  [7:0] busRdData;
    wire        intN;
    logic [3:0] sr1Ev;
    logic [3:0] alarm;
    logic [7:0] sr2Ev;
    logic [7:0] info;
    logic [7:0] syncSt;
    logic [7:0] d;
    int         mismatches;
    int         comparisons;
    lsi_host_model host (.clk(clk), .busRdData(busRdData),
        .busAddr(busAddr), .busWrStb(busWrStb), .busRdStb(busRdStb),
        .busWrData(busWrData));
    lsi_latched_status_irq_unit DUT (.clk(clk), .nrst(nrst),
        .busAddr(busAddr), .busWrStb(busWrStb), .busRdStb(busRdStb),
        .busWrData(busWrData), .busRdData(busRdData), .intN(intN),
        .sr1Events(sr1Ev), .unframedAllOnesAlarm(alarm[3]),
        .remoteAlarmFlag(alarm[2]), .carrierLossAlarm(alarm[1]),
        .syncLossAlarm(alarm[0]), .sr2Events(sr2Ev),
        .txElasticFull(info[7]), .txElasticEmpty(info[6]),
        .jitterBufferLimitTrip(info[5]), .rxElasticFull(info[4]),
        .rxElasticEmpty(info[3]), .crcResyncMet(info[2]),
        .frameAlignResyncMet(info[1]), .multiframeResyncMet(info[0]),
        .synchronizerState(syncSt));
    task end_of_test;
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Each information flag latches, reads once, then stays clear
    task t_info;
        for (int i = 0; i < 8; i++) begin
            info <= 8'h01 << i;
            host.idle(1);
            info <= 8'h00;
            host.idle(5);
            host.poll(8'h08, 8'hFF, d);
            `CHK(d, 8'h01 << i)
            host.poll(8'h08, 8'hFF, d);
            `CHK(d, 8'h00)
        end
    endtask
    // Masked poll refreshes only the chosen bits
    task t_mask;
        info <= 8'h81;
        host.idle(1);
        info <= 8'h00;
        host.idle(5);
        host.poll(8'h08, 8'h01, d);
        `CHK(d, 8'h01)
        host.poll(8'h08, 8'h80, d);
        `CHK(d, 8'h80)
    endtask
    // Alarm interrupts on both edges, released by a read
    task t_alarm;
        host.poll(8'h16, 8'h01, d);
        alarm <= 4'h1;
        host.idle(6);
        `CHK(intN, 1'b0)
        host.poll(8'h06, 8'h01, d);
        `CHK(d, 8'h01)
        host.idle(2);
        `CHK(intN, 1'b1)
        host.poll(8'h06, 8'h01, d);
        `CHK(d, 8'h01)
        alarm <= 4'h0;
        host.idle(6);
        `CHK(intN, 1'b0)
        host.poll(8'h06, 8'h01, d);
        host.poll(8'h06, 8'h01, d);
        `CHK(d, 8'h00)
        host.idle(2);
        `CHK(intN, 1'b1)
    endtask
    // Status one events and the other alarms, per-bit enables
    task t_sr1;
        host.poll(8'h16, 8'hF0, d);
        `CHK(d, 8'hF0)
        sr1Ev <= 4'hF;
        alarm <= 4'hE;
        host.idle(1);
        sr1Ev <= 4'h0;
        host.idle(6);
        `CHK(intN, 1'b0)
        host.poll(8'h06, 8'hFE, d);
        `CHK(d, 8'hFE)
        host.idle(2);
        `CHK(intN, 1'b1)
        host.poll(8'h06, 8'hFE, d);
        `CHK(d, 8'h0E)
        alarm <= 4'h0;
        host.idle(6);
        `CHK(intN, 1'b1)
        host.poll(8'h06, 8'hFE, d);
        `CHK(d, 8'h0E)
        host.poll(8'h06, 8'hFE, d);
        `CHK(d, 8'h00)
    endtask
    // Event interrupt masked, then enabled and released
    task t_event;
        sr2Ev <= 8'hFF;
        host.idle(1);
        sr2Ev <= 8'h00;
        host.idle(6);
        `CHK(intN, 1'b1)
        host.poll(8'h07, 8'hFF, d);
        `CHK(d, 8'hFF)
        host.poll(8'h17, 8'h08, d);
        sr2Ev <= 8'h08;
        host.idle(1);
        sr2Ev <= 8'h00;
        host.idle(6);
        `CHK(intN, 1'b0)
        host.poll(8'h07, 8'h08, d);
        host.idle(2);
        `CHK(intN, 1'b1)
    endtask
    // Live status read without a mask write; writes ignored
    task t_sync;
        host.rd(8'hC6, d);
        `CHK(d, 8'h00)
        syncSt <= 8'hA5;
        host.idle(6);
        host.rd(8'h1E, d);
        `CHK(d, 8'hA5)
        syncSt <= 8'h5A;
        host.cyc(1'b1, 1'b0, 8'h1E, 8'hFF);
        host.idle(6);
        host.rd(8'h1E, d);
        `CHK(d, 8'h5A)
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200000;
        mismatches++;
        end_of_test;
    end
    initial begin
        nrst = 1'b0;
        sr1Ev = 4'h0;
        alarm = 4'h0;
        sr2Ev = 8'h00;
        info = 8'h00;
        syncSt = 8'h00;
        mismatches = 0;
        comparisons = 0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        `CHK(intN, 1'b1)
        `CHK(busRdData, 8'h00)
        t_info;
        t_mask;
        t_alarm;
        t_sr1;
        t_event;
        t_sync;
        end_of_test;
    end
endmodule
bind lsi_latched_status_irq_unit lsi_unit_checker chk (.clk(clk),
    .nrst(nrst), .busAddr(busAddr), .busWrStb(busWrStb),
    .busRdStb(busRdStb), .busWrData(busWrData), .busRdData(busRdData),
    .intN(intN), .sr1Events(sr1Events),
    .unframedAllOnesAlarm(unframedAllOnesAlarm),
    .remoteAlarmFlag(remoteAlarmFlag), .carrierLossAlarm(carrierLossAlarm),
    .syncLossAlarm(syncLossAlarm), .sr2Events(sr2Events),
    .synchronizerState(synchronizerState));
`default_nettype wire
